/* File: logic/gx_consts.vh */
// constants for the gpio expander core: offsets, resets, bus codes
// assumes byte-wide registers reached by a 4-bit index
`ifndef GX_CONSTS_VH
`define GX_CONSTS_VH
// ************************************************
// register indices
// ************************************************
`define GX_REG_INPUT    4'h0
`define GX_REG_OUTPUT   4'h1
`define GX_REG_POLARITY 4'h2
`define GX_REG_CONFIG   4'h3
`define GX_REG_DRIVE0   4'h4
`define GX_REG_DRIVE1   4'h5
`define GX_REG_LATCH    4'h6
`define GX_REG_PULLEN   4'h7
`define GX_REG_PULLSEL  4'h8
`define GX_REG_MASK     4'h9
`define GX_REG_STATUS   4'hA
`define GX_REG_ODMODE   4'hB
// ************************************************
// reset values
// ************************************************
`define GX_RST_OUTPUT   8'hFF
`define GX_RST_POLARITY 8'h00
`define GX_RST_CONFIG   8'hFF
`define GX_RST_DRIVE    8'hFF
`define GX_RST_LATCH    8'h00
`define GX_RST_PULLEN   8'h00
`define GX_RST_PULLSEL  8'hFF
`define GX_RST_MASK     8'h00
`define GX_RST_ODMODE   8'h00
// ************************************************
// serial bus codes
// ************************************************
`define GX_ADDR_HI      6'h10
`define GX_GC_ADDR      8'h00
`define GX_SWRST_BYTE   8'h06
`define GX_BITS_BYTE    4'h8
`endif

/* File: logic/gx_core.v */
// gpio expander core: serial target, register file, change alert
// assumes scl, sda, pins and straps are asynchronous to clock
`timescale 1ns/1ps
`include "gx_consts.vh"
module gx_core
(
  input  wire       clock,
  input  wire       rst,
  input  wire       clkEn,
  input  wire       resetN,
  input  wire       addrStrap,
  input  wire       scl,
  input  wire       sdaIn,
  output wire       sdaOut,
  output wire       sdaOe,
  input  wire [7:0] expPinsIn,
  output wire [7:0] expPinsOut,
  output wire [7:0] expPinsOe,
  output wire [15:0] driveStrength,
  output wire [7:0] pullEnable,
  output wire [7:0] pullSelect,
  output wire       alertOut,
  output wire       alertOe,
  output wire       irq,
  input  wire [3:0] regAddr,
  input  wire [7:0] regWdata,
  input  wire       regWr,
  input  wire       regRd,
  output wire [7:0] regRdata
);
  // ************************************************
  // state encodings
  // ************************************************
  localparam [6:0] S_IDLE  = 7'h01;
  localparam [6:0] S_ADDR  = 7'h02;
  localparam [6:0] S_AACK  = 7'h04;
  localparam [6:0] S_WBYTE = 7'h08;
  localparam [6:0] S_WACK  = 7'h10;
  localparam [6:0] S_RBYTE = 7'h20;
  localparam [6:0] S_RACK  = 7'h40;

  // ************************************************
  // input synchronisation
  // ************************************************
  wire [11:0] syncQ;
  gx_sync
  #(
    .W    (12),
    .INIT (12'hC00)
  )
  uSync
  (
    .clock (clock),
    .rst   (rst),
    .clkEn (clkEn),
    .d     ({scl, sdaIn, resetN, addrStrap, expPinsIn}),
    .q     (syncQ)
  );
  wire       sclS   = syncQ[11];
  wire       sdaS   = syncQ[10];
  wire       resetS = syncQ[9];
  wire       strapS = syncQ[8];
  wire [7:0] pinS   = syncQ[7:0];

  // ************************************************
  // declarations
  // ************************************************
  reg        sclD;
  reg        sdaD;
  reg        swRst;
  reg        refresh;
  reg        strapAddr;
  reg  [6:0] state;
  reg  [3:0] bitCnt;
  reg  [7:0] shiftR;
  reg        sdaDrive;
  reg        isRead;
  reg        isGc;
  reg        gotCmd;
  reg  [3:0] ptr;
  reg        swArm;
  reg        masterAck;
  reg        i2cWr;
  reg  [7:0] i2cData;
  reg        readAck;
  reg  [7:0] outReg;
  reg  [7:0] polReg;
  reg  [7:0] cfgReg;
  reg  [7:0] drv0;
  reg  [7:0] drv1;
  reg  [7:0] latchReg;
  reg  [7:0] pullEnReg;
  reg  [7:0] pullSelReg;
  reg  [7:0] maskReg;
  reg  [7:0] odReg;
  reg  [7:0] inReg;
  reg  [7:0] snapInput;
  reg  [7:0] latchVal;
  reg  [7:0] diffD;
  reg        alertReg;
  reg  [7:0] rdData;
  wire [7:0] status;
  wire       coreRst = rst | ~resetS | swRst;
  wire       sclRise = sclS & ~sclD;
  wire       sclFall = ~sclS & sclD;
  wire       startC  = sclS & sclD & sdaD & ~sdaS;
  wire       stopC   = sclS & sclD & ~sdaD & sdaS;
  wire       byteIn  = (bitCnt == `GX_BITS_BYTE);

  // ************************************************
  // register read decode, shared by both ports
  // ************************************************
  function [7:0] rdMux;
    input [3:0] a;
    begin
      case (a)
        `GX_REG_INPUT:    rdMux = inReg;
        `GX_REG_OUTPUT:   rdMux = outReg;
        `GX_REG_POLARITY: rdMux = polReg;
        `GX_REG_CONFIG:   rdMux = cfgReg;
        `GX_REG_DRIVE0:   rdMux = drv0;
        `GX_REG_DRIVE1:   rdMux = drv1;
        `GX_REG_LATCH:    rdMux = latchReg;
        `GX_REG_PULLEN:   rdMux = pullEnReg;
        `GX_REG_PULLSEL:  rdMux = pullSelReg;
        `GX_REG_MASK:     rdMux = maskReg;
        `GX_REG_STATUS:   rdMux = status;
        `GX_REG_ODMODE:   rdMux = odReg;
        default:          rdMux = 8'h00;
      endcase
    end
  endfunction
  // byte at the serial pointer, loaded into the read shifter
  wire [7:0] rdPtr = rdMux(ptr);

  // ************************************************
  // edge history and reset release
  // ************************************************
  always @(posedge clock)
  begin
    if (rst)
    begin
      sclD <= 1'b1;
      sdaD <= 1'b1;
    end
    else if (clkEn)
    begin
      sclD <= sclS;
      sdaD <= sdaS;
    end
  end

  // strap and input caught the cycle after any reset ends
  always @(posedge clock)
  begin
    if (coreRst)
      refresh <= 1'b1;
    else if (clkEn)
      refresh <= 1'b0;
  end

  always @(posedge clock)
  begin
    if (rst)
      strapAddr <= 1'b0;
    else if (clkEn && refresh)
      strapAddr <= strapS;
  end

  // ************************************************
  // serial target state machine
  // ************************************************
  always @(posedge clock)
  begin
    if (coreRst)
    begin
      state     <= S_IDLE;
      bitCnt    <= 4'h0;
      shiftR    <= 8'h00;
      sdaDrive  <= 1'b0;
      isRead    <= 1'b0;
      isGc      <= 1'b0;
      gotCmd    <= 1'b0;
      ptr       <= 4'h0;
      swArm     <= 1'b0;
      swRst     <= 1'b0;
      masterAck <= 1'b0;
      i2cWr     <= 1'b0;
      i2cData   <= 8'h00;
      readAck   <= 1'b0;
    end
    else if (clkEn)
    begin
      i2cWr   <= 1'b0;
      readAck <= 1'b0;
      if (startC)
      begin
        state    <= S_ADDR;
        bitCnt   <= 4'h0;
        sdaDrive <= 1'b0;
        swArm    <= 1'b0;
      end
      else if (stopC)
      begin
        state    <= S_IDLE;
        sdaDrive <= 1'b0;
        swRst    <= swArm;
        swArm    <= 1'b0;
      end
      else
      begin
        case (state)
          S_IDLE:
            sdaDrive <= 1'b0;
          S_ADDR, S_WBYTE:
            if (sclRise && !byteIn)
            begin
              shiftR <= {shiftR[6:0], sdaS};
              bitCnt <= bitCnt + 4'h1;
            end
            else if (sclFall && byteIn && state == S_ADDR)
            begin
              bitCnt <= 4'h0;
              if (shiftR[7:1] == {`GX_ADDR_HI, strapAddr})
              begin
                sdaDrive <= 1'b1;
                isRead   <= shiftR[0];
                isGc     <= 1'b0;
                state    <= S_AACK;
              end
              else if (shiftR == `GX_GC_ADDR)
              begin
                sdaDrive <= 1'b1;
                isRead   <= 1'b0;
                isGc     <= 1'b1;
                state    <= S_AACK;
              end
              else
                state <= S_IDLE;
            end
            else if (sclFall && byteIn)
            begin
              bitCnt <= 4'h0;
              if (isGc)
              begin
                if (!gotCmd && shiftR == `GX_SWRST_BYTE)
                begin
                  sdaDrive <= 1'b1;
                  swArm    <= 1'b1;
                  gotCmd   <= 1'b1;
                  state    <= S_WACK;
                end
                else
                begin
                  swArm <= 1'b0;
                  state <= S_IDLE;
                end
              end
              else
              begin
                sdaDrive <= 1'b1;
                gotCmd   <= 1'b1;
                state    <= S_WACK;
                if (!gotCmd)
                  ptr <= shiftR[3:0];
                else
                begin
                  i2cWr   <= 1'b1;
                  i2cData <= shiftR;
                end
              end
            end
          S_AACK:
            if (sclFall)
            begin
              gotCmd <= 1'b0;
              if (isRead)
              begin
                sdaDrive <= ~rdPtr[7];
                shiftR   <= {rdPtr[6:0], 1'b0};
                bitCnt   <= 4'h1;
                state    <= S_RBYTE;
              end
              else
              begin
                sdaDrive <= 1'b0;
                bitCnt   <= 4'h0;
                state    <= S_WBYTE;
              end
            end
          S_WACK:
            if (sclFall)
            begin
              sdaDrive <= 1'b0;
              bitCnt   <= 4'h0;
              state    <= S_WBYTE;
            end
          S_RBYTE:
            if (sclFall)
            begin
              if (byteIn)
              begin
                sdaDrive <= 1'b0;
                state    <= S_RACK;
              end
              else
              begin
                sdaDrive <= ~shiftR[7];
                shiftR   <= {shiftR[6:0], 1'b0};
                bitCnt   <= bitCnt + 4'h1;
              end
            end
          S_RACK:
            if (sclRise)
            begin
              masterAck <= ~sdaS;
              readAck   <= (ptr == `GX_REG_INPUT);
            end
            else if (sclFall)
            begin
              if (masterAck)
              begin
                sdaDrive <= ~rdPtr[7];
                shiftR   <= {rdPtr[6:0], 1'b0};
                bitCnt   <= 4'h1;
                state    <= S_RBYTE;
              end
              else
                state <= S_IDLE;
            end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end

  // ************************************************
  // register file, serial writes win over local ones
  // ************************************************
  wire       wrEn = i2cWr | regWr;
  wire [3:0] wrA  = i2cWr ? ptr : regAddr;
  wire [7:0] wrD  = i2cWr ? i2cData : regWdata;
  wire [7:0] clr  = (wrEn && wrA == `GX_REG_STATUS) ? wrD : 8'h00;

  always @(posedge clock)
  begin
    if (coreRst)
    begin
      outReg     <= `GX_RST_OUTPUT;
      polReg     <= `GX_RST_POLARITY;
      cfgReg     <= `GX_RST_CONFIG;
      drv0       <= `GX_RST_DRIVE;
      drv1       <= `GX_RST_DRIVE;
      latchReg   <= `GX_RST_LATCH;
      pullEnReg  <= `GX_RST_PULLEN;
      pullSelReg <= `GX_RST_PULLSEL;
      maskReg    <= `GX_RST_MASK;
      odReg      <= `GX_RST_ODMODE;
    end
    else if (clkEn && wrEn)
    begin
      case (wrA)
        `GX_REG_OUTPUT:   outReg     <= wrD;
        `GX_REG_POLARITY: polReg     <= wrD;
        `GX_REG_CONFIG:   cfgReg     <= wrD;
        `GX_REG_DRIVE0:   drv0       <= wrD;
        `GX_REG_DRIVE1:   drv1       <= wrD;
        `GX_REG_LATCH:    latchReg   <= wrD;
        `GX_REG_PULLEN:   pullEnReg  <= wrD;
        `GX_REG_PULLSEL:  pullSelReg <= wrD;
        `GX_REG_MASK:     maskReg    <= wrD;
        `GX_REG_ODMODE:   odReg      <= wrD;
        default:          odReg      <= odReg;
      endcase
    end
  end

  // ************************************************
  // input capture, latching and change alert
  // ************************************************
  // alert reference: only refresh, a read ack of input, or reset move it
  wire [7:0] diff   = (pinS ^ snapInput) & cfgReg;
  wire [7:0] inView = (latchReg & latchVal) | (~latchReg & pinS);

  always @(posedge clock)
  begin
    if (coreRst)
    begin
      inReg     <= 8'h00;
      snapInput <= 8'h00;
      latchVal  <= 8'h00;
      diffD     <= 8'h00;
      alertReg  <= 1'b0;
    end
    else if (clkEn)
    begin
      inReg    <= inView ^ polReg;
      latchVal <= (latchVal & status) | (pinS & ~status);
      diffD    <= diff;
      alertReg <= |(diff & ~maskReg);
      if (refresh || readAck)
        snapInput <= pinS;
    end
  end

  gx_irq
  #(
    .W (8)
  )
  uIrq
  (
    .clock  (clock),
    .rst    (coreRst),
    .clkEn  (clkEn),
    .setEv  (diff & ~diffD),
    .clear  (clr),
    .mask   (maskReg),
    .status (status),
    .irq    (irq)
  );

  // ************************************************
  // local read port, data one cycle after strobe
  // ************************************************
  always @(posedge clock)
  begin
    if (rst)
      rdData <= 8'h00;
    else if (clkEn)
      rdData <= regRd ? rdMux(regAddr) : 8'h00;
  end

  // ************************************************
  // pins
  // ************************************************
  // open-drain pins drive only the low level
  assign expPinsOut    = outReg;
  assign expPinsOe     = ~cfgReg & ~(odReg & outReg);
  assign driveStrength = {drv1, drv0};
  assign pullEnable    = pullEnReg;
  assign pullSelect    = pullSelReg;
  assign sdaOut        = 1'b0;
  assign sdaOe         = sdaDrive;
  assign alertOut      = 1'b0;
  assign alertOe       = alertReg;
  assign regRdata      = rdData;
endmodule // gx_core

/* File: logic/gx_irq.v */
// sticky per-pin status with write-one-to-clear and mask
// assumes events are one-cycle pulses on the same clock
`timescale 1ns/1ps
module gx_irq
#(
  parameter W = 8
)
(
  input  wire         clock,
  input  wire         rst,
  input  wire         clkEn,
  input  wire [W-1:0] setEv,
  input  wire [W-1:0] clear,
  input  wire [W-1:0] mask,
  output wire [W-1:0] status,
  output wire         irq
);
  reg [W-1:0] stat;
  always @(posedge clock)
  begin
    if (rst)
      stat <= {W{1'b0}};
    else if (clkEn)
      stat <= (stat & ~clear) | setEv; // set beats clear
  end
  assign status = stat;
  assign irq    = |(stat & ~mask);
endmodule // gx_irq

/* File: logic/gx_sync.v */
// two-stage synchroniser for a group of pin levels
// assumes each bit is an independent level from outside the clock
`timescale 1ns/1ps
module gx_sync
#(
  parameter         W    = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
)
(
  input  wire         clock,
  input  wire         rst,
  input  wire         clkEn,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta;
  reg [W-1:0] stable;
  // first stage feeds only the second
  always @(posedge clock)
  begin
    if (rst)
    begin
      meta   <= INIT;
      stable <= INIT;
    end
    else if (clkEn)
    begin
      meta   <= d;
      stable <= meta;
    end
  end
  assign q = stable;
endmodule // gx_sync

/* File: verification/gx_core_monitor.sv */
// assertions on the expander core ports
// assumes clkEn held high by the bench; bound from the bench top
`timescale 1ns/1ps
`include "gx_consts.vh"
module gx_core_monitor
(
  input wire        clock,
  input wire        rst,
  input wire        clkEn,
  input wire        resetN,
  input wire        addrStrap,
  input wire        scl,
  input wire        sdaIn,
  input wire        sdaOut,
  input wire        sdaOe,
  input wire [7:0]  expPinsIn,
  input wire [7:0]  expPinsOut,
  input wire [7:0]  expPinsOe,
  input wire [15:0] driveStrength,
  input wire [7:0]  pullEnable,
  input wire [7:0]  pullSelect,
  input wire        alertOut,
  input wire        alertOe,
  input wire        irq,
  input wire [3:0]  regAddr,
  input wire [7:0]  regWdata,
  input wire        regWr,
  input wire        regRd,
  input wire [7:0]  regRdata
);
  // ****************
  // port properties
  // ****************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  property p_rstDef;
    $fell(rst) |-> expPinsOe == 8'h00 && expPinsOut == 8'hFF && !sdaOe && !alertOe && !irq;
  endproperty
  a_rstDef: assert property (p_rstDef) else $error("defaults after reset");
  // sync delay of the pin is two to three edges, six leaves margin
  property p_pinReset;
    !resetN [*6] |-> expPinsOe == 8'h00 && expPinsOut == 8'hFF && !alertOe && !sdaOe;
  endproperty
  a_pinReset: assert property (p_pinReset) else $error("reset pin defaults");
  property p_outWr;
    regWr && regAddr == `GX_REG_OUTPUT |=> expPinsOut == $past(regWdata);
  endproperty
  a_outWr: assert property (p_outWr) else $error("output reg write");
  property p_cfgWr;
    regWr && regAddr == `GX_REG_CONFIG |=> (expPinsOe & $past(regWdata)) == 8'h00;
  endproperty
  a_cfgWr: assert property (p_cfgWr) else $error("input pin driven");
  property p_rdIdle;
    !regRd |=> regRdata == 8'h00;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
  property p_mask;
    regWr && regAddr == `GX_REG_MASK && regWdata == 8'hFF |=> !irq ##1 !alertOe;
  endproperty
  a_mask: assert property (p_mask) else $error("masked pin alerts");
  property p_outNoAlert;
    regWr && regAddr == `GX_REG_CONFIG && regWdata == 8'h00 |-> ##2 !alertOe;
  endproperty
  a_outNoAlert: assert property (p_outNoAlert) else $error("alert from outputs");
  property p_openDrain;
    sdaOut == 1'b0 && alertOut == 1'b0;
  endproperty
  a_openDrain: assert property (p_openDrain) else $error("open drain level");
  c_rd: cover property (regRd);
  c_ack: cover property ($rose(sdaOe));
  c_alert: cover property ($rose(alertOe));
  c_irq: cover property ($rose(irq));
endmodule // gx_core_monitor

/* File: verification/gx_core_tb.sv */
// self-checking bench for the gpio expander core
// assumes logic/ sources; clkEn tied high, freezing is not exercised
`timescale 1ns/1ps
`include "gx_consts.vh"
module gx_core_tb;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         resetN = 1'b1;
  reg         addrStrap = 1'b1;
  reg  [3:0]  regAddr = 4'h0;
  reg  [7:0]  regWdata = 8'h00;
  reg         regWr = 1'b0;
  reg         regRd = 1'b0;
  reg  [7:0]  extPins = 8'h00;
  reg         rdV = 1'b0;
  reg  [7:0]  expQ[$];
  reg  [7:0]  sh[0:15];
  reg  [8:0]  rx9;
  reg  [7:0]  v;
  reg  [7:0]  p;
  integer     i;
  integer     seed = 32'haa62;
  integer     n_fail = 0;
  integer     tests_run = 0;
  wire        scl, sdaDrv, sdaOut, sdaOe, alertOut, alertOe, irq;
  wire [7:0]  expPinsOut, expPinsOe, pullEnable, pullSelect, regRdata;
  wire [15:0] driveStrength;
  wire        sdaLine = sdaOe ? (sdaDrv & sdaOut) : sdaDrv;
  wire [7:0]  pinLine = (expPinsOe & expPinsOut) | (~expPinsOe & extPins);
  always #10 clock = ~clock;
  gx_core u_gx_core
  (
    .clock(clock), .rst(rst), .clkEn(1'b1), .resetN(resetN), .addrStrap(addrStrap),
    .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .expPinsIn(pinLine),
    .expPinsOut(expPinsOut), .expPinsOe(expPinsOe), .driveStrength(driveStrength),
    .pullEnable(pullEnable), .pullSelect(pullSelect), .alertOut(alertOut),
    .alertOe(alertOe), .irq(irq), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata)
  );
  gx_i2c_host u_gx_i2c_host (.clock(clock), .scl(scl), .sdaDrv(sdaDrv), .sdaLine(sdaLine));
  // ****************
  // tasks
  // ****************
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e)
      begin
        n_fail = n_fail + 1;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // strobes stand until the next call, so accesses run back to back
  task acc(input w, input r, input [3:0] a, input [7:0] d);
    begin
      @(posedge clock);
      regWr <= w;
      regRd <= r;
      regAddr <= a;
      regWdata <= d;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    acc(1'b1, 1'b0, a, d);
  endtask
  task rd(input [3:0] a, input [7:0] e);
    begin
      expQ.push_back(e);
      acc(1'b0, 1'b1, a, 8'h00);
    end
  endtask
  task idle;
    acc(1'b0, 1'b0, 4'h0, 8'h00);
  endtask
  task sb(input [7:0] b, input e);
    begin
      u_gx_i2c_host.xfer({b, 1'b1}, rx9);
      chk("sdaAck", {15'h0000, e}, {15'h0000, rx9[0]});
    end
  endtask
  function [7:0] dflt(input [3:0] a);
    case (a)
      `GX_REG_OUTPUT: dflt = `GX_RST_OUTPUT;
      `GX_REG_CONFIG: dflt = `GX_RST_CONFIG;
      `GX_REG_DRIVE0, `GX_REG_DRIVE1: dflt = `GX_RST_DRIVE;
      `GX_REG_PULLSEL: dflt = `GX_RST_PULLSEL;
      default: dflt = 8'h00;
    endcase
  endfunction
  task close_out;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  always @(posedge clock)
  begin
    rdV <= regRd;
    if (rdV)
      chk("regRdata", {8'h00, expQ.pop_front()}, {8'h00, regRdata});
  end
  initial
  begin
    #200_000;
    n_fail = n_fail + 1;
    close_out;
  end
  // ****************
  // scenarios
  // ****************
  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    for (i = 0; i < 16; i = i + 1)
      rd(i[3:0], dflt(i[3:0]));
    for (i = 1; i < 12; i = i + 1)
      if (i != 10)
      begin
        sh[i] = 8'($random(seed));
        wr(i[3:0], sh[i]);
        rd(i[3:0], sh[i]);
      end
    idle;
    @(posedge clock);
    chk("expPinsOut", {8'h00, sh[1]}, {8'h00, expPinsOut});
    chk("expPinsOe", {8'h00, ~sh[3] & ~(sh[11] & sh[1])}, {8'h00, expPinsOe});
    chk("drive", {sh[5], sh[4]}, driveStrength);
    chk("pulls", {sh[7], sh[8]}, {pullEnable, pullSelect});
    $display("test registers done");
    p = 8'($random(seed));
    v = 8'($random(seed));
    wr(`GX_REG_CONFIG, 8'hFF);
    wr(`GX_REG_LATCH, 8'h00);
    wr(`GX_REG_MASK, 8'h00);
    wr(`GX_REG_POLARITY, p);
    wr(`GX_REG_INPUT, ~v);
    idle;
    extPins <= v;
    repeat (6) @(posedge clock);
    rd(`GX_REG_INPUT, v ^ p);
    idle;
    u_gx_i2c_host.start;
    sb({`GX_ADDR_HI, addrStrap, 1'b0}, 1'b0);
    sb({4'h0, `GX_REG_INPUT}, 1'b0);
    u_gx_i2c_host.start;
    sb({`GX_ADDR_HI, addrStrap, 1'b1}, 1'b0);
    u_gx_i2c_host.xfer(9'h1FF, rx9);
    u_gx_i2c_host.stop;
    chk("serialRead", {8'h00, v ^ p}, {8'h00, rx9[8:1]});
    chk("alertRead", 16'h0000, {15'h0000, alertOe});
    wr(`GX_REG_STATUS, 8'hFF);
    idle;
    extPins <= v ^ 8'h01;
    repeat (8) @(posedge clock);
    chk("alertSet", 16'h0003, {14'h0000, alertOe, irq});
    extPins <= v;
    repeat (8) @(posedge clock);
    chk("alertBack", 16'h0001, {14'h0000, alertOe, irq});
    rd(`GX_REG_STATUS, 8'h01);
    wr(`GX_REG_STATUS, 8'h01);
    wr(`GX_REG_MASK, 8'hFF);
    idle;
    extPins <= ~v;
    repeat (8) @(posedge clock);
    chk("masked", 16'h0000, {14'h0000, alertOe, irq});
    wr(`GX_REG_MASK, 8'h00);
    wr(`GX_REG_CONFIG, 8'h00);
    idle;
    repeat (8) @(posedge clock);
    chk("outNoAlert", 16'h0000, {15'h0000, alertOe});
    $display("test alert done");
    p = 8'($random(seed));
    u_gx_i2c_host.start;
    sb({`GX_ADDR_HI, addrStrap, 1'b0}, 1'b0);
    sb({4'h0, `GX_REG_OUTPUT}, 1'b0);
    sb(p, 1'b0);
    u_gx_i2c_host.stop;
    chk("serialWrite", {8'h00, p}, {8'h00, expPinsOut});
    u_gx_i2c_host.start;
    sb({`GX_ADDR_HI, ~addrStrap, 1'b0}, 1'b1);
    u_gx_i2c_host.stop;
    for (i = 0; i < 5; i = i + 1)
    begin
      u_gx_i2c_host.start;
      sb(`GX_GC_ADDR | {7'h00, i == 3}, i == 3);
      if (i != 3)
        sb(i == 0 ? 8'h07 : `GX_SWRST_BYTE, i == 0);
      if (i == 1)
        sb(`GX_SWRST_BYTE, 1'b1);
      if (i == 2)
        u_gx_i2c_host.start;
      if (i == 2)
        sb(8'hA0, 1'b1);
      u_gx_i2c_host.stop;
      repeat (4) @(posedge clock);
      chk("softReset", {8'h00, i == 4 ? `GX_RST_OUTPUT : p}, {8'h00, expPinsOut});
    end
    $display("test serial done");
    wr(`GX_REG_OUTPUT, 8'h00);
    wr(`GX_REG_CONFIG, 8'h00);
    idle;
    extPins <= 8'hA5;
    resetN <= 1'b0;
    addrStrap <= 1'b0;
    repeat (8) @(posedge clock);
    resetN <= 1'b1;
    repeat (8) @(posedge clock);
    chk("pinReset", 16'h00FF, {expPinsOe, expPinsOut});
    chk("refresh", 16'h0000, {15'h0000, alertOe});
    rd(`GX_REG_INPUT, 8'hA5);
    idle;
    u_gx_i2c_host.start;
    sb({`GX_ADDR_HI, 1'b0, 1'b0}, 1'b0);
    u_gx_i2c_host.stop;
    $display("test reset pin done");
    close_out;
  end
endmodule // gx_core_tb
bind gx_core gx_core_monitor u_gx_core_monitor
(
  .clock(clock), .rst(rst), .clkEn(clkEn), .resetN(resetN), .addrStrap(addrStrap),
  .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .expPinsIn(expPinsIn),
  .expPinsOut(expPinsOut), .expPinsOe(expPinsOe), .driveStrength(driveStrength),
  .pullEnable(pullEnable), .pullSelect(pullSelect), .alertOut(alertOut),
  .alertOe(alertOe), .irq(irq), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata)
);

/* File: verification/gx_i2c_host.sv */
// serial bus controller model, 160 ns bit period
// assumes an open-drain data line pulled up in the bench
`timescale 1ns/1ps
module gx_i2c_host
(
  input  wire clock,
  output reg  scl = 1'b1,
  output reg  sdaDrv = 1'b1,
  input  wire sdaLine
);
  // ****************
  // bus conditions
  // ****************
  // clock stands high between frames; start doubles as repeated start
  task start;
    begin
      // frames run on falling edges, off the core's sampling edge
      @(negedge clock);
      #80 sdaDrv = 1'b1;
      #80 scl = 1'b1;
      #80 sdaDrv = 1'b0;
      #80 scl = 1'b0;
    end
  endtask
  task stop;
    begin
      #80 sdaDrv = 1'b0;
      #80 scl = 1'b1;
      #80 sdaDrv = 1'b1;
      #80;
    end
  endtask
  // nine bits msb first; a one releases the line
  task xfer(input [8:0] tx, output [8:0] rx);
    integer i;
    begin
      for (i = 8; i >= 0; i = i - 1)
      begin
        #40 sdaDrv = tx[i];
        #40 scl = 1'b1;
        #40 rx[i] = sdaLine;
        #40 scl = 1'b0;
      end
    end
  endtask
endmodule // gx_i2c_host
